// *** tb.sv ***
// self-checking bench for the usb host control register block
// assumes uhcc_pkg and uhcc_map.svh are compiled ahead; drives dut ports directly
`timescale 1ns/1ps
module tb
  import uhcc_pkg::*;
;
  logic        clk_in, rst_in, perst_n_in, global_reset_n_in, rate_strap_input_in;
  uhcc_req_t   cfg_in;
  logic [3:0]  power_request_in, port_power_outputs_out, power_pulldown_en_out, port_off_out;
  logic [3:0]  port_off_two;
  logic [31:0] cfg_rdata_out, bar2_out, bar3_out, seen;
  logic        cfg_rvalid_out, clock_spread_off_out, osc_restart_out, power_switch_cap_flag_out;
  logic [5:0]  pll_rate_choice_out, osc_rate_select_out;
  logic [7:0]  next_ptr_out, nptr_src;
  logic [31:0] bar2_src, bar3_src;
  logic        pulse;
  int          errors, n_tests, cycles;

  uhcc_top dut (
    .clk_in, .rst_in, .perst_n_in, .global_reset_n_in, .cfg_in, .cfg_rdata_out,
    .cfg_rvalid_out, .rate_strap_input_in, .power_request_in, .port_power_outputs_out,
    .power_pulldown_en_out, .clock_spread_off_out, .osc_restart_out, .pll_rate_choice_out,
    .osc_rate_select_out, .next_ptr_in(nptr_src), .bar2_in(bar2_src),
    .bar3_in(bar3_src), .next_ptr_out, .bar2_out, .bar3_out,
    .power_switch_cap_flag_out, .port_off_out
  );

  // two-port build sees the same traffic; only its port disables are watched
  uhcc_top #(.NUM_PORTS(2)) dut2 (
    .clk_in, .rst_in, .perst_n_in, .global_reset_n_in, .cfg_in, .cfg_rdata_out(),
    .cfg_rvalid_out(), .rate_strap_input_in, .power_request_in, .port_power_outputs_out(),
    .power_pulldown_en_out(), .clock_spread_off_out(), .osc_restart_out(),
    .pll_rate_choice_out(), .osc_rate_select_out(), .next_ptr_in(nptr_src),
    .bar2_in(bar2_src), .bar3_in(bar3_src), .next_ptr_out(), .bar2_out(),
    .bar3_out(), .power_switch_cap_flag_out(), .port_off_out(port_off_two)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // whole sequence needs well under 400 cycles
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      print_verdict();
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one access; returns once derived outputs have caught up with a write
  task acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_in);
    cfg_in <= '{wr: w, rd: !w, addr: a, be: be, wdata: d};
    @(posedge clk_in);
    cfg_in <= '0;
    #1;
    seen = cfg_rdata_out;
    pulse = osc_restart_out;
    chk("rvalid", 32'(!w), 32'(cfg_rvalid_out));
    @(posedge clk_in);
    #1;
  endtask : acc

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 4'hF, 32'h0);
    chk("rdata", exp, seen);
  endtask : rdchk

  // m is {power-on, pci express, global}; resync of the pins needs two edges
  task rst_hit(input logic [2:0] m);
    @(posedge clk_in);
    {rst_in, perst_n_in, global_reset_n_in} <= m ^ 3'b011;
    repeat (3) @(posedge clk_in);
    {rst_in, perst_n_in, global_reset_n_in} <= 3'b011;
    repeat (4) @(posedge clk_in);
    #1;
  endtask : rst_hit

  initial begin
    {rst_in, perst_n_in, global_reset_n_in, rate_strap_input_in} = 4'hF;
    power_request_in = 4'h5;
    {nptr_src, bar2_src, bar3_src} = {8'h80, 32'hF000_0000, 32'h0000_0008};
    cfg_in = '0;
    errors = 0;
    n_tests = 0;
    cycles = 0;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    rdchk(8'hE0, 32'h0);
    chk("power", 32'hA, 32'(port_power_outputs_out));
    chk("pulldown", 32'hF, 32'(power_pulldown_en_out));
    chk("cap", 32'h1, 32'(power_switch_cap_flag_out));
    chk("nptr", 32'h80, 32'(next_ptr_out));
    chk("bar2", 32'hF000_0000, bar2_out);
    chk("bar3", 32'h0000_0008, bar3_out);
    // a first write of zero to the restart bit still uses up its one write
    acc(1'b1, 8'hE0, 4'h8, 32'h3F00_0000);
    chk("pll", 32'h3F, 32'(pll_rate_choice_out));
    chk("osc", 32'h3F, 32'(osc_rate_select_out));
    acc(1'b1, 8'hE0, 4'h8, 32'hC000_0000);
    chk("restart", 32'h0, 32'(pulse));
    chk("spread", 32'h1, 32'(clock_spread_off_out));
    rdchk(8'hE0, 32'h8000_0000);
    rst_hit(3'b100);
    acc(1'b1, 8'hE0, 4'h8, 32'h5500_0000);
    chk("restart", 32'h1, 32'(pulse));
    acc(1'b1, 8'hE0, 4'h8, 32'h2A00_0000);
    chk("restart", 32'h0, 32'(pulse));
    rdchk(8'hE0, 32'h5500_0000);
    @(posedge clk_in);
    rate_strap_input_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    chk("pll", 32'h0, 32'(pll_rate_choice_out));
    chk("osc", 32'h0, 32'(osc_rate_select_out));
    acc(1'b1, 8'hE0, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'hE0, 32'hD5C1_0F00);
    chk("power", 32'h5, 32'(port_power_outputs_out));
    chk("pulldown", 32'h0, 32'(power_pulldown_en_out));
    chk("cap", 32'h0, 32'(power_switch_cap_flag_out));
    chk("port_off", 32'hF, 32'(port_off_out));
    chk("port_off_two", 32'h3, 32'(port_off_two));
    chk("nptr", 32'h0, 32'(next_ptr_out));
    chk("bar2", 32'h0, bar2_out);
    chk("bar3", 32'h0, bar3_out);
    acc(1'b1, 8'hE4, 4'hF, 32'h0);
    rdchk(8'hE4, 32'h0);
    acc(1'b1, 8'hE0, 4'h2, 32'h0);
    rdchk(8'hE0, 32'hD5C1_0000);
    rst_hit(3'b010);
    rdchk(8'hE0, 32'h5540_0000);
    rst_hit(3'b001);
    rdchk(8'hE0, 32'h0);
    chk("power", 32'hA, 32'(port_power_outputs_out));
    print_verdict();
  end
endmodule : tb

// *** uhcc_map.svh ***
// named offsets, bit positions and reset values of the usb host control register
// included by the package and the top module; definitions only
`ifndef UHCC_MAP_SVH
`define UHCC_MAP_SVH
`define UHCC_CTL_OFS      8'hE0
`define UHCC_CTL_RESET    32'h0000_0000
`define UHCC_SPREAD_BIT   31
`define UHCC_RESTART_BIT  30
`define UHCC_PLL_HI       29
`define UHCC_PLL_LO       24
`define UHCC_HIDE_BIT     23
`define UHCC_POL_BIT      22
`define UHCC_NOPPC_BIT    16
`define UHCC_DIS_HI       11
`define UHCC_DIS_LO       8
`define UHCC_RSVD_A_MASK  32'h003E_0000
`define UHCC_RSVD_B_MASK  32'h0000_F000
`define UHCC_NOREM_MASK   32'h0000_00FF
`define UHCC_PTR_HIDDEN   8'h00
`define UHCC_BAR_HIDDEN   32'h0000_0000
`define UHCC_PLL_DEFAULT  6'h00
`endif

// *** uhcc_pkg.sv ***
// types shared by the usb host control register block
// assumes uhcc_map.svh sits in the include path
package uhcc_pkg;
  `include "uhcc_map.svh"
  // stored fields of the control register
  typedef struct packed {
    logic       spread_off;
    logic       restart;
    logic [5:0] pll;
    logic       hide;
    logic       pol;
    logic       no_ppc;
    logic [3:0] port_off;
  } uhcc_ctl_t;
  // one configuration access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } uhcc_req_t;
endpackage : uhcc_pkg

// *** uhcc_top.sv ***
// usb host control configuration register with its output controls
// assumes a config-space agent issuing single-cycle read/write strobes on clk_in;
// rst_in is the internal power-on reset; pci express and global resets arrive on pins
//
// Operation
// - power-on or global reset clears the whole register to zero.
// - bit 31 set turns off usb clock spread spectrum.
// - writing 1 to bit 30 restarts the oscillator with current frequency settings.
// - only the first write to bit 30 after power-up is accepted.
// - strap high: bits 29:24 drive pll and oscillator frequency selects.
// - strap low: bits 29:24 have no effect on pll or oscillator.
// - after bit 30 is set, bits 29:24 cannot change.
// - bit 23 set hides capability pointer at 71h and bars at 18h, 1Ch.
// - bit 22 clear: power outputs active low, pull-downs enabled.
// - bit 22 set: power outputs active high, pull-downs disabled.
// - bits 21:17 read as zero.
// - bit 16 clear reports the port power control capability as 1.
// - bit 16 set reports the port power control capability as 0.
// - bits 15:12 read as zero.
// - bits 8 to 11 disable downstream ports 1 to 4.
// - on a two-port build, port 3 and 4 disables do nothing.
// - bits 30, 29:24 and 22 survive a pci express reset.
`timescale 1ns/1ps
// the guard in the map header makes this second include harmless
`include "uhcc_map.svh"

module uhcc_top
  import uhcc_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  // clock and resets
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        perst_n_in,
  input  wire logic        global_reset_n_in,
  // configuration access
  input  wire uhcc_req_t   cfg_in,
  output logic [31:0]      cfg_rdata_out,
  output logic             cfg_rvalid_out,
  // pins and strap
  input  wire logic        rate_strap_input_in,
  input  wire logic [3:0]  power_request_in,
  output logic [3:0]       port_power_outputs_out,
  output logic [3:0]       power_pulldown_en_out,
  // clocking controls
  output logic             clock_spread_off_out,
  output logic             osc_restart_out,
  output logic [5:0]       pll_rate_choice_out,
  output logic [5:0]       osc_rate_select_out,
  // capability, hiding and port disables
  input  wire logic [7:0]  next_ptr_in,
  input  wire logic [31:0] bar2_in,
  input  wire logic [31:0] bar3_in,
  output logic [7:0]       next_ptr_out,
  output logic [31:0]      bar2_out,
  output logic [31:0]      bar3_out,
  output logic             power_switch_cap_flag_out,
  output logic [3:0]       port_off_out
);

  // two-stage synchronisers for perst, global reset and the strap
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
    end else begin
      sync_a <= {perst_n_in, global_reset_n_in, rate_strap_input_in};
      sync_b <= sync_a;
    end
  end

  wire perst_hit  = ~sync_b[2];
  wire global_reset_n_hit   = ~sync_b[1];
  wire strap_high = sync_b[0];
  wire sticky_clr = rst_in | global_reset_n_hit;
  wire plain_clr  = sticky_clr | perst_hit;

  uhcc_ctl_t ctl;
  logic      restart_used;

  // write decode
  wire        hit      = cfg_in.addr == `UHCC_CTL_OFS;
  wire        wr_hit   = cfg_in.wr & hit;
  wire [31:0] wd       = cfg_in.wdata;
  wire        be3      = wr_hit & cfg_in.be[3];
  wire        be2      = wr_hit & cfg_in.be[2];
  wire        be1      = wr_hit & cfg_in.be[1];
  wire        pll_lock = ctl.restart;
  wire        rst_take = be3 & ~restart_used;
  wire        rst_fire = rst_take & wd[`UHCC_RESTART_BIT];

  // no port may be disabled beyond the ones the build has
  wire [3:0] port_exist = 4'((5'h01 << NUM_PORTS) - 5'h01);

  // read image; reserved and non-removable bits read as zero
  wire [31:0] ctl_word;
  assign ctl_word[`UHCC_SPREAD_BIT]            = ctl.spread_off;
  assign ctl_word[`UHCC_RESTART_BIT]           = ctl.restart;
  assign ctl_word[`UHCC_PLL_HI:`UHCC_PLL_LO]   = ctl.pll;
  assign ctl_word[`UHCC_HIDE_BIT]              = ctl.hide;
  assign ctl_word[`UHCC_POL_BIT]               = ctl.pol;
  assign ctl_word[`UHCC_POL_BIT-1:`UHCC_NOPPC_BIT+1] = 5'h00;
  assign ctl_word[`UHCC_NOPPC_BIT]             = ctl.no_ppc;
  assign ctl_word[`UHCC_NOPPC_BIT-1:`UHCC_DIS_HI+1]  = 4'h0;
  assign ctl_word[`UHCC_DIS_HI:`UHCC_DIS_LO]   = ctl.port_off;
  assign ctl_word[`UHCC_DIS_LO-1:0]            = 8'h00;

  wire [31:0] next_rdata = (cfg_in.rd & hit) ? ctl_word : `UHCC_CTL_RESET;

  // write-once tracking lasts until the next power-up only
  always_ff @(posedge clk_in) begin
    if (rst_in)
      restart_used <= 1'b0;
    else if (be3)
      restart_used <= 1'b1;
  end

  // one process owns the whole register so each field has a single driver;
  // sticky fields see only power-on or global reset, and a clear beats a write
  always_ff @(posedge clk_in) begin
    if (sticky_clr) begin
      ctl.restart <= 1'b0;
      ctl.pll     <= `UHCC_PLL_DEFAULT;
      ctl.pol     <= 1'b0;
    end else begin
      if (rst_take)
        ctl.restart <= wd[`UHCC_RESTART_BIT];
      if (be3 & ~pll_lock)
        ctl.pll <= wd[`UHCC_PLL_HI:`UHCC_PLL_LO];
      if (be2)
        ctl.pol <= wd[`UHCC_POL_BIT];
    end
    if (plain_clr) begin
      ctl.spread_off <= 1'b0;
      ctl.hide       <= 1'b0;
      ctl.no_ppc     <= 1'b0;
      ctl.port_off   <= 4'h0;
    end else begin
      if (be3)
        ctl.spread_off <= wd[`UHCC_SPREAD_BIT];
      if (be2)
        ctl.hide <= wd[`UHCC_HIDE_BIT];
      if (be2)
        ctl.no_ppc <= wd[`UHCC_NOPPC_BIT];
      if (be1)
        ctl.port_off <= wd[`UHCC_DIS_HI:`UHCC_DIS_LO];
    end
  end

  // output decode
  wire [5:0] next_pll   = strap_high ? ctl.pll : `UHCC_PLL_DEFAULT;
  wire [3:0] next_power = ctl.pol ? power_request_in : ~power_request_in;
  wire [3:0] next_pdown = {4{~ctl.pol}};
  wire [3:0] next_off   = ctl.port_off & port_exist;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_rdata_out  <= `UHCC_CTL_RESET;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rdata_out  <= next_rdata;
      cfg_rvalid_out <= cfg_in.rd;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      osc_restart_out <= 1'b0;
    end else begin
      osc_restart_out <= rst_fire;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      clock_spread_off_out      <= 1'b0;
      pll_rate_choice_out       <= `UHCC_PLL_DEFAULT;
      osc_rate_select_out       <= `UHCC_PLL_DEFAULT;
      power_switch_cap_flag_out <= 1'b1;
      port_off_out              <= 4'h0;
    end else begin
      clock_spread_off_out      <= ctl.spread_off;
      pll_rate_choice_out       <= next_pll;
      osc_rate_select_out       <= next_pll;
      power_switch_cap_flag_out <= ~ctl.no_ppc;
      port_off_out              <= next_off;
    end
  end

  // pins stay at the inactive low-polarity level until reset ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      port_power_outputs_out <= 4'hF;
      power_pulldown_en_out  <= 4'hF;
    end else begin
      port_power_outputs_out <= next_power;
      power_pulldown_en_out  <= next_pdown;
    end
  end

  // hiding is applied here so the config mux downstream stays unaware of it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      next_ptr_out <= `UHCC_PTR_HIDDEN;
      bar2_out     <= `UHCC_BAR_HIDDEN;
      bar3_out     <= `UHCC_BAR_HIDDEN;
    end else begin
      next_ptr_out <= ctl.hide ? `UHCC_PTR_HIDDEN : next_ptr_in;
      bar2_out     <= ctl.hide ? `UHCC_BAR_HIDDEN : bar2_in;
      bar3_out     <= ctl.hide ? `UHCC_BAR_HIDDEN : bar3_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  spread_follow_a: assert property (
    ctl.spread_off |=> clock_spread_off_out)
    else $error("spread off not reflected");

  restart_pulse_a: assert property (
    rst_fire |=> osc_restart_out ##1 !osc_restart_out)
    else $error("restart pulse wrong");

  write_once_a: assert property (
    (restart_used && !sticky_clr) |=> ctl.restart == $past(ctl.restart))
    else $error("restart bit changed twice");

  pll_strap_a: assert property (
    strap_high |=> pll_rate_choice_out == $past(ctl.pll))
    else $error("pll select not from field");

  pll_ignore_a: assert property (
    !strap_high |=> pll_rate_choice_out == `UHCC_PLL_DEFAULT)
    else $error("pll select used field while strap low");

  pll_locked_a: assert property (
    (pll_lock && !sticky_clr) |=> $stable(ctl.pll))
    else $error("pll field changed while locked");

  hide_bar_a: assert property (
    ctl.hide |=> bar2_out == 32'h0 && bar3_out == 32'h0 && next_ptr_out == 8'h0)
    else $error("hidden items visible");

  // the edge that ends reset still loads the parked pin level, so it is left out
  power_pol_a: assert property (
    (!rst_in && !ctl.pol) |=> port_power_outputs_out == ~$past(power_request_in)
                 && power_pulldown_en_out == 4'hF)
    else $error("low polarity power wrong");

  power_high_a: assert property (
    ctl.pol |=> port_power_outputs_out == $past(power_request_in)
                && power_pulldown_en_out == 4'h0)
    else $error("high polarity power wrong");

  rsvd_zero_a: assert property (
    cfg_rvalid_out |-> (cfg_rdata_out & `UHCC_RSVD_A_MASK) == 32'h0)
    else $error("reserved 21:17 nonzero");

  ppc_flag_a: assert property (
    ##1 power_switch_cap_flag_out == !$past(ctl.no_ppc))
    else $error("power switch flag wrong");

  rsvd_b_zero_a: assert property (
    cfg_rvalid_out |-> (cfg_rdata_out & `UHCC_RSVD_B_MASK) == 32'h0)
    else $error("reserved 15:12 nonzero");

  port_absent_a: assert property (
    (port_off_out & ~port_exist) == 4'h0)
    else $error("absent port disabled");

  perst_keep_a: assert property (
    (perst_hit && !sticky_clr && !be2) |=> $stable(ctl.pol) && ctl.spread_off == 1'b0)
    else $error("perst cleared sticky or kept plain");

  clr_zero_a: assert property (
    sticky_clr |=> ctl_word == `UHCC_CTL_RESET)
    else $error("register not cleared");

  // registered outputs load reset values on the releasing edge, hence the rst_in guard
  cap_absent_a: assert property (
    (!rst_in && ctl.no_ppc) |=> !power_switch_cap_flag_out)
    else $error("power switch flag set while bit 16 set");

  port_follow_a: assert property (
    !rst_in |=> port_off_out == ($past(ctl.port_off) & port_exist))
    else $error("port disables not applied");

  spread_clear_a: assert property (
    (!rst_in && !ctl.spread_off) |=> !clock_spread_off_out)
    else $error("spread off set while bit 31 clear");

  restart_c: cover property (rst_fire ##1 osc_restart_out);
  pol_high_c: cover property (ctl.pol && strap_high);
  relock_c:  cover property (pll_lock && be3);
  hide_c:    cover property (ctl.hide && cfg_rvalid_out);
  perst_c:   cover property (perst_hit && ctl.pol);

endmodule : uhcc_top
